// [hdl/swo_div.v]
/*
  sequential signed divider by the fixed rate divisor, rounding half away
  from zero. assumes a single clock and that start is a one-cycle pulse
  given only while busy is low.
*/
`timescale 1ns/1ps
`include "swo_map.vh"

module swo_div #(
  parameter W = 32
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         start,
  input  wire [W-1:0] dividend,
  output reg          busy_r,
  output reg          done_r,
  output reg  [W-1:0] quot_r
);

  reg  [W-1:0] rem_r;
  reg  [W-1:0] mag_r;
  reg  [5:0]   cnt_r;
  reg          neg_r;
  wire [W-1:0] rem_sh;
  wire [W-1:0] div_c;
  wire [W-1:0] mag_in;
  wire [W-1:0] q_round;

  assign div_c   = `SWO_RATE_DIV;
  assign mag_in  = dividend[W-1] ? (~dividend + {{(W-1){1'b0}}, 1'b1}) : dividend;
  assign rem_sh  = {rem_r[W-2:0], mag_r[W-1]};
  // round up when remainder reaches half the divisor
  assign q_round = (rem_r >= `SWO_RATE_HALF) ? (mag_r + {{(W-1){1'b0}}, 1'b1}) : mag_r;

  // restoring division, one quotient bit per clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r  <= {W{1'b0}};
      mag_r  <= {W{1'b0}};
      cnt_r  <= 6'h00;
      neg_r  <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      quot_r <= {W{1'b0}};
    end else begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        rem_r  <= {W{1'b0}};
        mag_r  <= mag_in;
        neg_r  <= dividend[W-1];
        cnt_r  <= W[5:0];
        busy_r <= 1'b1;
      end else if (busy_r && cnt_r != 6'h00) begin
        if (rem_sh >= div_c) begin
          rem_r <= rem_sh - div_c;
          mag_r <= {mag_r[W-2:0], 1'b1};
        end else begin
          rem_r <= rem_sh;
          mag_r <= {mag_r[W-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 6'h01;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        quot_r <= neg_r ? (~q_round + {{(W-1){1'b0}}, 1'b1}) : q_round;
      end
    end
  end

endmodule // swo_div

// [hdl/swo_map.vh]
/*
  register map, field positions, reset values and arithmetic constants of the
  scale-with-offset datapath. assumes it is included by bare name.
*/
`ifndef SWO_MAP_VH
`define SWO_MAP_VH

// register byte offsets on apb
`define SWO_CTRL_OFF    12'h000
`define SWO_SRC_OFF     12'h004
`define SWO_RATE_OFF    12'h008
`define SWO_OFS_OFF     12'h00C
`define SWO_DEST_OFF    12'h010
`define SWO_FLAG_OFF    12'h014
`define SWO_IRQ_ST_OFF  12'h018
`define SWO_IRQ_MSK_OFF 12'h01C

// arithmetic flag positions
`define SWO_FLG_CARRY   0
`define SWO_FLG_OVF     1
`define SWO_FLG_ZERO    2
`define SWO_FLG_SIGN    3
`define SWO_FLG_MINOR   4
`define SWO_ERRCODE_LSB 16

// interrupt status positions
`define SWO_IRQ_DONE    0
`define SWO_IRQ_OVF     1
`define SWO_IRQ_MINOR   2

// control bit positions
`define SWO_CTRL_GO     0
`define SWO_CTRL_CLRMIN 1

// constants
`define SWO_RATE_DIV    32'd10000
`define SWO_RATE_HALF   32'd5000
`define SWO_POS_LIM     16'h7FFF
`define SWO_NEG_LIM     16'h8000
`define SWO_ERR_CODE    16'h0020
`define SWO_RST_WORD    16'h0000
`define SWO_RST_FLAGS   5'h00

`endif

// [hdl/swo_top.v]
/*
  scale-with-offset datapath: destination = round(source * rate / 10000)
  + offset, saturated to signed 16 bits, with arithmetic flags, minor error
  latch and a maskable interrupt. assumes one 100 MHz clock, an apb master
  and that the controlling program clears the minor error itself.
*/
// Notes on behaviour
// - multiply source by rate, round, add offset, write destination.
// - rate is entered value over ten thousand; all operands signed 16-bit.
// - overflow flag set on overflow, cleared when no overflow.
// - overflow also sets the minor error bit.
// - on overflow destination saturates to most negative or most positive.
// - overflow tested on scaled product and again after offset added.
// - scaled product above positive limit writes positive limit, any offset.
// - scaled product positive overflow raises minor error with fixed code.
// - zero flag set when destination written is zero, else cleared.
// - sign flag set when destination written is negative, else cleared.
`timescale 1ns/1ps
`include "swo_map.vh"

module swo_top (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  output reg         IRQ,
  output reg         BUSY,
  output reg         MINOR_ERR
);

  localparam ST_IDLE = 2'b00;
  localparam ST_MUL  = 2'b01;
  localparam ST_DIV  = 2'b10;
  localparam ST_FIN  = 2'b11;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [15:0] src_r;
  reg  [15:0] rate_r;
  reg  [15:0] ofs_r;
  reg  [15:0] dest_r;
  reg  [31:0] prod_r;
  reg  [4:0]  flags_r;
  reg  [15:0] err_code_r;
  reg  [2:0]  irq_st_r;
  reg  [2:0]  irq_msk_r;
  reg         pready_r;
  wire        div_busy;
  wire        div_done;
  wire [31:0] div_q;

  // flag word as software sees it
  function [31:0] flag_word;
    input [4:0]  f;
    input [15:0] code;
    begin
      flag_word = {code, 11'h000, f};
    end
  endfunction

  // word-aligned address match
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a[11:2] == off[11:2]);
    end
  endfunction

  wire apb_acc  = PSEL & PENABLE & ~pready_r;
  wire apb_wr   = apb_acc & PWRITE;
  wire apb_rd   = apb_acc & ~PWRITE;
  wire wr_ctrl  = apb_wr & hit(PADDR, `SWO_CTRL_OFF);
  wire start_op = wr_ctrl & PWDATA[`SWO_CTRL_GO] & (state_r == ST_IDLE);
  wire clr_min  = wr_ctrl & PWDATA[`SWO_CTRL_CLRMIN];
  wire rd_irq   = apb_rd & hit(PADDR, `SWO_IRQ_ST_OFF);
  wire mapped   = hit(PADDR, `SWO_CTRL_OFF) | hit(PADDR, `SWO_SRC_OFF)
                | hit(PADDR, `SWO_RATE_OFF) | hit(PADDR, `SWO_OFS_OFF)
                | hit(PADDR, `SWO_DEST_OFF) | hit(PADDR, `SWO_FLAG_OFF)
                | hit(PADDR, `SWO_IRQ_ST_OFF) | hit(PADDR, `SWO_IRQ_MSK_OFF);

  // signed operands
  // sign-extended operands; product of two 16-bit signed fits 32 bits
  wire signed [31:0] src_s  = {{16{src_r[15]}}, src_r};
  wire signed [31:0] rate_s = {{16{rate_r[15]}}, rate_r};
  wire signed [31:0] mul_s  = src_s * rate_s;

  swo_div #(
    .W (32)
  ) u_div (
    .clk      (CLK),
    .rst_n    (RST_N),
    .start    (state_r == ST_MUL),
    .dividend (prod_r),
    .busy_r   (div_busy),
    .done_r   (div_done),
    .quot_r   (div_q)
  );

  // first check
  // overflow of scaled product before the offset
  wire pre_pos = ~div_q[31] & (div_q[30:15] != 16'h0000);
  wire pre_neg = div_q[31] & (div_q[30:15] != 16'hFFFF);
  // second check
  // sum after offset, 17 bits to catch the carry out
  wire [16:0] sum    = {div_q[15], div_q[15:0]} + {ofs_r[15], ofs_r};
  wire        post_v = sum[16] ^ sum[15];
  wire        ovf    = pre_pos | pre_neg | post_v;

  // saturated result
  reg [15:0] res;
  always @* begin
    res = sum[15:0];
    if (pre_pos)
      res = `SWO_POS_LIM;
    else if (pre_neg)
      res = `SWO_NEG_LIM;
    else if (post_v)
      res = sum[16] ? `SWO_NEG_LIM : `SWO_POS_LIM;
  end

  // operation sequencer
  always @* begin
    case (state_r)
      ST_IDLE: state_nxt = start_op ? ST_MUL : ST_IDLE;
      ST_MUL:  state_nxt = ST_DIV;
      ST_DIV:  state_nxt = div_done ? ST_FIN : ST_DIV;
      ST_FIN:  state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // product register and destination update
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prod_r <= 32'h00000000;
      dest_r <= `SWO_RST_WORD;
    end else begin
      if (start_op)
        prod_r <= mul_s;
      if (state_r == ST_DIV && div_done)
        dest_r <= res;
    end
  end

  // arithmetic flags and minor error latch
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_r    <= `SWO_RST_FLAGS;
      err_code_r <= `SWO_RST_WORD;
    end else begin
      // clear first so a fresh overflow wins
      if (clr_min) begin
        flags_r[`SWO_FLG_MINOR] <= 1'b0;
        err_code_r              <= `SWO_RST_WORD;
      end
      if (state_r == ST_DIV && div_done) begin
        flags_r[`SWO_FLG_OVF]  <= ovf;
        flags_r[`SWO_FLG_ZERO] <= (res == 16'h0000);
        flags_r[`SWO_FLG_SIGN] <= res[15];
        flags_r[`SWO_FLG_CARRY] <= flags_r[`SWO_FLG_CARRY];
        if (ovf) begin
          flags_r[`SWO_FLG_MINOR] <= 1'b1;
          err_code_r              <= `SWO_ERR_CODE;
        end
      end
    end
  end

  // interrupt status: set wins over read-clear
  wire [2:0] irq_ev = {3{state_r == ST_DIV && div_done}}
                    & {1'b1, ovf, 1'b1} & 3'h7;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_st_r  <= 3'h0;
      irq_msk_r <= 3'h0;
    end else begin
      irq_st_r <= (rd_irq ? 3'h0 : irq_st_r) | irq_ev;
      if (apb_wr && hit(PADDR, `SWO_IRQ_MSK_OFF))
        irq_msk_r <= PWDATA[2:0];
    end
  end

  // operand registers
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      src_r  <= `SWO_RST_WORD;
      rate_r <= `SWO_RST_WORD;
      ofs_r  <= `SWO_RST_WORD;
    end else begin
      if (apb_wr && hit(PADDR, `SWO_SRC_OFF))
        src_r <= PWDATA[15:0];
      if (apb_wr && hit(PADDR, `SWO_RATE_OFF))
        rate_r <= PWDATA[15:0];
      if (apb_wr && hit(PADDR, `SWO_OFS_OFF))
        ofs_r <= PWDATA[15:0];
    end
  end

  // apb answer: one wait cycle, ready registered
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_r <= 1'b0;
      PREADY   <= 1'b0;
      PSLVERR  <= 1'b0;
      PRDATA   <= 32'h00000000;
    end else begin
      pready_r <= apb_acc;
      PREADY   <= apb_acc;
      PSLVERR  <= apb_acc & ~mapped;
      if (apb_rd) begin
        if (hit(PADDR, `SWO_CTRL_OFF))
          PRDATA <= {31'h00000000, state_r != ST_IDLE};
        else if (hit(PADDR, `SWO_SRC_OFF))
          PRDATA <= {16'h0000, src_r};
        else if (hit(PADDR, `SWO_RATE_OFF))
          PRDATA <= {16'h0000, rate_r};
        else if (hit(PADDR, `SWO_OFS_OFF))
          PRDATA <= {16'h0000, ofs_r};
        else if (hit(PADDR, `SWO_DEST_OFF))
          PRDATA <= {16'h0000, dest_r};
        else if (hit(PADDR, `SWO_FLAG_OFF))
          PRDATA <= flag_word(flags_r, err_code_r);
        else if (rd_irq)
          PRDATA <= {29'h00000000, irq_st_r};
        else if (hit(PADDR, `SWO_IRQ_MSK_OFF))
          PRDATA <= {29'h00000000, irq_msk_r};
        else
          PRDATA <= 32'h00000000;
      end
    end
  end

  // pin outputs from flops
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ       <= 1'b0;
      BUSY      <= 1'b0;
      MINOR_ERR <= 1'b0;
    end else begin
      IRQ       <= |(irq_st_r & irq_msk_r);
      BUSY      <= (state_nxt != ST_IDLE);
      MINOR_ERR <= flags_r[`SWO_FLG_MINOR];
    end
  end

endmodule // swo_top

// [test/swo_seq.sv]
/*
  sequencer model: apb master issuing operand and control transfers.
  assumes one clock; signals change by nonblocking right after edges.
*/
`timescale 1ns/1ps
module swo_seq (
  input  wire        CLK,
  input  wire        PREADY,
  input  wire        PSLVERR,
  input  wire [31:0] PRDATA,
  output reg         PSEL,
  output reg         PENABLE,
  output reg         PWRITE,
  output reg  [11:0] PADDR,
  output reg  [31:0] PWDATA
);
  // idle bus at time zero
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
  end
  // one transfer held until pready, released bus shows inverse
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    begin
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1) @(posedge CLK);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      PADDR <= ~a;
      PWDATA <= ~d;
    end
  endtask
endmodule // swo_seq

// [test/swo_top_properties.sv]
/*
  port checks of the scaling datapath: apb answer and status timing.
  assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module swo_top_properties (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic BUSY,
  input wire logic MINOR_ERR
);
  // all checks on the one clock
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no answer after access");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE))
    else $error("ready without access");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_busy_min: assert property ($rose(BUSY) |-> BUSY [*8])
    else $error("busy too short");
  a_busy_end: assert property ($rose(BUSY) |-> ##[8:60] !BUSY)
    else $error("busy never ends");
  a_minor_cause: assert property ($rose(MINOR_ERR) |->
    $past(BUSY) || $past(BUSY, 2) || $past(BUSY, 3))
    else $error("minor error outside operation");
  a_minor_clear: assert property ($fell(MINOR_ERR) |->
    $past(PSEL && PWRITE, 2) || $past(PSEL && PWRITE, 3))
    else $error("minor error dropped without write");
endmodule // swo_top_properties

// [test/swo_top_tb.sv]
/*
  testbench of the scaling datapath: operand sets, flags, irq, errors.
  assumes the register map header and the sequencer model.
*/
`timescale 1ns/1ps
`include "swo_map.vh"
module swo_top_tb;
  logic        CLK = 1'b0;
  logic        RST_N;
  wire         PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, BUSY, MINOR_ERR;
  wire  [11:0] PADDR;
  wire  [31:0] PWDATA, PRDATA;
  logic [31:0] q;
  logic        e;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          i;
  // 100 MHz clock
  always #5 CLK = ~CLK;
  swo_top u_swo_top (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .BUSY(BUSY),
    .MINOR_ERR(MINOR_ERR));
  swo_seq u_seq (.CLK(CLK), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA));
  task close_out;
    begin
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    begin
      n_tests++;
      if (g !== x) begin
        n_fail++;
        $display("Error at %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_seq.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    begin
      u_seq.xfer(1'b0, a, 32'h0, q, e);
      chk(q, x);
    end
  endtask
  // clear minor error, load operands, start, wait, compare result
  task op(input logic [15:0] s, input logic [15:0] r, input logic [15:0] o,
          input logic [31:0] xd, input logic [31:0] xf);
    begin
      wr(`SWO_CTRL_OFF, 32'h2);
      wr(`SWO_SRC_OFF, {16'h0, s});
      wr(`SWO_RATE_OFF, {16'h0, r});
      wr(`SWO_OFS_OFF, {16'h0, o});
      wr(`SWO_CTRL_OFF, 32'h1);
      for (i = 0; i < 5 && BUSY !== 1'b1; i++) @(posedge CLK);
      for (i = 0; i < 99 && BUSY !== 1'b0; i++) @(posedge CLK);
      rd(`SWO_DEST_OFF, xd);
      rd(`SWO_FLAG_OFF, xf);
    end
  endtask
  // hang guard
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      close_out;
    end
  end
  initial begin
    RST_N = 1'b0;
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    rd(`SWO_FLAG_OFF, 32'h0);
    rd(`SWO_DEST_OFF, 32'h0);
    wr(`SWO_IRQ_MSK_OFF, 32'h7);
    rd(`SWO_IRQ_MSK_OFF, 32'h7);
    rd(`SWO_CTRL_OFF, 32'h0);
    op(16'h0064, 16'h4E20, 16'h0005, 32'h00CD, 32'h0);
    chk({31'h0, IRQ}, 32'h1);
    rd(`SWO_IRQ_ST_OFF, 32'h5);
    repeat (2) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h0);
    wr(`SWO_IRQ_MSK_OFF, 32'h0);
    op(16'h0003, 16'h1388, 16'hFFFE, 32'h0, 32'h4);
    chk({31'h0, IRQ}, 32'h0);
    op(16'hFFF9, 16'h2710, 16'h0000, 32'hFFF9, 32'h8);
    op(16'h0003, 16'hEC78, 16'h0000, 32'hFFFE, 32'h8);
    op(16'h7530, 16'h4E20, 16'h8000, 32'h7FFF, 32'h00200012);
    chk({31'h0, MINOR_ERR}, 32'h1);
    op(16'h0064, 16'h4E20, 16'h0005, 32'h00CD, 32'h0);
    chk({31'h0, MINOR_ERR}, 32'h0);
    op(16'h8AD0, 16'h4E20, 16'h7FFF, 32'h8000, 32'h0020001A);
    op(16'h7530, 16'h2710, 16'h1388, 32'h7FFF, 32'h00200012);
    op(16'h8AD0, 16'h2710, 16'hEC78, 32'h8000, 32'h0020001A);
    u_seq.xfer(1'b0, 12'h020, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    close_out;
  end
endmodule // swo_top_tb
bind swo_top swo_top_properties u_chk (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .BUSY(BUSY), .MINOR_ERR(MINOR_ERR));
